/* File: hdl/ispa_input_pin_assign.sv */
`timescale 1ns/100ps
`default_nettype none
module ispa_input_pin_assign (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [ispa_pkg::NUM_PINS-1:0] pin_i,
  output logic [ispa_pkg::NUM_FUNCS-1:0] func_o,
  output logic control_change_input_o,
  output logic abs_transfer_mode_input_o
);
  localparam int N = ispa_pkg::NUM_PINS;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_sel_addr(input logic [5:0] addr, input int idx);
    return addr[5:2] == (ispa_pkg::OFS_SEL_BASE[5:2] + 4'(idx));
  endfunction

  ispa_pkg::ispa_bus_state_t state;
  ispa_pkg::ispa_bus_state_t next_state;
  ispa_pkg::ispa_mode_t mode;

  logic [N-1:0] pin_s;
  logic [15:0] sel_pend [0:N-1];
  logic [15:0] sel_act [0:N-1];
  logic abs_pend;
  logic abs_act;
  logic [2:0] cc_pend;
  logic [2:0] cc_act;
  logic [ispa_pkg::NUM_FUNCS-1:0] dec_func [0:N-1];
  logic [ispa_pkg::NUM_FUNCS-1:0] next_func;
  logic next_cc;
  logic [N-1:0] sel_diff;
  logic [31:0] rd_word;

  wire acc = avs_read_i | avs_write_i;
  wire ack = (state == ispa_pkg::BUS_ACK);
  wire wr_go = ack & avs_write_i;
  wire [5:0] wa = {avs_address_i[5:2], 2'b00};
  wire wr_ctrl = wr_go && (wa == ispa_pkg::OFS_CTRL);
  wire wr_cfg = wr_go && (wa == ispa_pkg::OFS_CONFIG);
  wire [31:0] ctrl_word = {23'h000000, 1'b0, 6'h00, mode};
  wire [31:0] cfg_word = {25'h0000000, cc_pend, 3'h0, abs_pend};
  wire [31:0] ctrl_new = be_merge(ctrl_word, avs_writedata_i, avs_byteenable_i);
  wire [31:0] cfg_new = be_merge(cfg_word, avs_writedata_i, avs_byteenable_i);
  // a restart copies the pending settings into the working set, as a power cycle would
  wire restart = wr_ctrl && ctrl_new[ispa_pkg::CTRL_RESTART_BIT]; // R9
  wire pend_diff = (|sel_diff) || (abs_pend != abs_act) || (cc_pend != cc_act);

  assign avs_waitrequest_o = acc & ~ack;

  ispa_pin_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(pin_i),
    .sync_o(pin_s)
  );

  for (genvar i = 0; i < N; i++) begin : g_pin
    wire wr_sel = wr_go && is_sel_addr(avs_address_i, i);
    wire [31:0] sel_new = be_merge({16'h0000, sel_pend[i]}, avs_writedata_i, avs_byteenable_i);
    wire is_abs = abs_act && (i == ispa_pkg::ABS_PIN); // R8
    // absolute transfer mode outranks a control-change placement on the same pin
    wire is_cc = (cc_act == 3'(i + 1)) && !is_abs; // R7

    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        sel_pend[i] <= ispa_pkg::SEL_RST[i]; // R1 R2 R3 R4
      end else if (wr_sel) begin
        sel_pend[i] <= sel_new[15:0];
      end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        sel_act[i] <= ispa_pkg::SEL_RST[i]; // R1 R2 R3 R4
      end else if (restart) begin
        sel_act[i] <= sel_pend[i]; // R9
      end
    end

    assign sel_diff[i] = sel_pend[i] != sel_act[i];

    ispa_func_decode u_dec ( // R5
      .sel_i(sel_act[i]),
      .mode_i(mode),
      .pin_i(pin_s[i]),
      .forced_i(is_abs | is_cc),
      .func_o(dec_func[i])
    );
  end

  always_comb begin
    next_func = '0;
    next_cc = 1'b0;
    for (int i = 0; i < N; i++) begin
      next_func = next_func | dec_func[i];
      if (cc_act == 3'(i + 1) && !(abs_act && i == ispa_pkg::ABS_PIN)) begin
        next_cc = next_cc | pin_s[i]; // R7
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      func_o <= '0;
      control_change_input_o <= 1'b0;
      abs_transfer_mode_input_o <= 1'b0;
    end else begin
      func_o <= next_func;
      control_change_input_o <= next_cc;
      abs_transfer_mode_input_o <= abs_act & pin_s[ispa_pkg::ABS_PIN]; // R8
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= ispa_pkg::ispa_mode_t'(ispa_pkg::MODE_RST);
      abs_pend <= ispa_pkg::ABS_RST;
      cc_pend <= ispa_pkg::CC_NONE;
    end else begin
      if (wr_ctrl) begin
        mode <= ispa_pkg::ispa_mode_t'(ctrl_new[ispa_pkg::CTRL_MODE_LSB +: 2]); // R6
      end
      if (wr_cfg) begin
        abs_pend <= cfg_new[ispa_pkg::CFG_ABS_BIT];
        cc_pend <= cfg_new[ispa_pkg::CFG_CC_LSB +: 3];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      abs_act <= ispa_pkg::ABS_RST;
      cc_act <= ispa_pkg::CC_NONE;
    end else if (restart) begin
      abs_act <= abs_pend; // R8 R9
      cc_act <= cc_pend; // R7 R9
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    case (wa)
      ispa_pkg::OFS_CTRL: rd_word = ctrl_word;
      ispa_pkg::OFS_CONFIG: rd_word = cfg_word;
      ispa_pkg::OFS_STATUS: begin
        rd_word[ispa_pkg::ST_PIN_LSB +: N] = pin_s;
        rd_word[ispa_pkg::ST_PEND_BIT] = pend_diff;
        rd_word[ispa_pkg::ST_ABS_BIT] = abs_transfer_mode_input_o;
        rd_word[ispa_pkg::ST_CC_BIT] = control_change_input_o;
        rd_word[ispa_pkg::ST_FUNC_LSB +: ispa_pkg::NUM_FUNCS] = func_o;
      end
      default: begin
        for (int i = 0; i < N; i++) begin
          if (is_sel_addr(avs_address_i, i)) begin
            rd_word = {16'h0000, sel_pend[i]};
          end
        end
      end
    endcase
  end

  always_comb begin
    case (state)
      ispa_pkg::BUS_IDLE: next_state = acc ? ispa_pkg::BUS_ACK : ispa_pkg::BUS_IDLE;
      ispa_pkg::BUS_ACK: next_state = ispa_pkg::BUS_IDLE;
      default: next_state = ispa_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ispa_pkg::BUS_IDLE;
      avs_readdata_o <= 32'h00000000;
    end else begin
      state <= next_state;
      if (state == ispa_pkg::BUS_IDLE && avs_read_i) begin
        avs_readdata_o <= rd_word;
      end
    end
  end
endmodule // ispa_input_pin_assign
`default_nettype wire

/* File: hdl/ispa_pkg.sv */
// Function
// R1: setting 4 routes a function to connector A pin 8; resets to 0665.
// R2: setting 5 routes a function to connector B pin 7; resets to 0770.
// R3: setting 6 routes a function to connector B pin 8; resets to 0883.
// R4: setting 7 routes a function to connector B pin 9; resets to 0994.
// R5: all selection settings share one table of assignable functions and one decoder.
// R6: each setting holds one digit per control mode; the active mode's digit is used.
// R7: a pin carrying the control-change input ignores its own selection setting.
// R8: absolute detection forces connector B pin 8 to the absolute-data transfer mode input.
// R9: selection changes take effect only after the next reset or restart; rst_i here reloads SEL_RST instead, so only a restart applies them.
`default_nettype none
package ispa_pkg;
  localparam int NUM_PINS = 5;
  localparam int NUM_FUNCS = 15;
  localparam int ABS_PIN = 3;

  typedef enum logic [1:0] {
    MODE_POSITION = 2'h0,
    MODE_SPEED = 2'h1,
    MODE_TORQUE = 2'h2
  } ispa_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } ispa_bus_state_t;

  // pin order: connector B pin 14, A pin 8, B pin 7, B pin 8, B pin 9
  localparam logic [15:0] SEL_RST [0:NUM_PINS-1] = '{16'h0222, 16'h0665, 16'h0770, 16'h0883, 16'h0994}; // R1 R2 R3 R4

  // digit of each control mode inside a selection setting
  localparam int DIG_POS_LSB = 8;
  localparam int DIG_SPD_LSB = 4;
  localparam int DIG_TRQ_LSB = 0;

  // codes that each mode accepts; any other code selects nothing
  localparam logic [15:0] VALID_POS = 16'h783E;
  localparam logic [15:0] VALID_SPD = 16'h67FE;
  localparam logic [15:0] VALID_TRQ = 16'h67E6;

  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CONFIG = 6'h04;
  localparam logic [5:0] OFS_SEL_BASE = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h1C;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RESTART_BIT = 8;
  localparam int CFG_ABS_BIT = 0;
  localparam int CFG_CC_LSB = 4;
  localparam int ST_PIN_LSB = 0;
  localparam int ST_PEND_BIT = 8;
  localparam int ST_ABS_BIT = 9;
  localparam int ST_CC_BIT = 10;
  localparam int ST_FUNC_LSB = 16;

  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic ABS_RST = 1'b0;
  localparam logic [2:0] CC_NONE = 3'h0;
endpackage
`default_nettype wire

/* File: hdl/ispa_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module ispa_pin_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ispa_pkg::NUM_PINS-1:0] async_i,
  output logic [ispa_pkg::NUM_PINS-1:0] sync_o
);
  logic [ispa_pkg::NUM_PINS-1:0] stage1;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // ispa_pin_sync
`default_nettype wire

/* File: hdl/ispa_func_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module ispa_func_decode (
  input wire logic [15:0] sel_i,
  input wire ispa_pkg::ispa_mode_t mode_i,
  input wire logic pin_i,
  input wire logic forced_i,
  output logic [ispa_pkg::NUM_FUNCS-1:0] func_o
);
  wire [3:0] code;
  wire [15:0] valid;
  wire [15:0] hot;

  assign code = (mode_i == ispa_pkg::MODE_SPEED) ? sel_i[ispa_pkg::DIG_SPD_LSB +: 4] : // R6
                (mode_i == ispa_pkg::MODE_TORQUE) ? sel_i[ispa_pkg::DIG_TRQ_LSB +: 4] :
                sel_i[ispa_pkg::DIG_POS_LSB +: 4];
  // mode code 3 is undefined and selects nothing
  assign valid = (mode_i == ispa_pkg::MODE_POSITION) ? ispa_pkg::VALID_POS :
                 (mode_i == ispa_pkg::MODE_SPEED) ? ispa_pkg::VALID_SPD :
                 (mode_i == ispa_pkg::MODE_TORQUE) ? ispa_pkg::VALID_TRQ : 16'h0000;
  assign hot = 16'h0001 << code;
  assign func_o = (pin_i && !forced_i && valid[code]) ? hot[ispa_pkg::NUM_FUNCS-1:0] : '0; // R5 R7
endmodule // ispa_func_decode
`default_nettype wire

/* File: tb/ispa_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ispa_ctrl_model (
  input wire logic core_clk_i,
  input wire logic [4:0] level_i,
  input wire logic slow_i,
  output logic [4:0] pin_o
);
  logic [4:0] held = 5'h00;
  logic [4:0] drv = 5'h00;
  assign pin_o = drv;
  // slow mode lags one more cycle, like a sluggish controller output stage
  always @(posedge core_clk_i) begin
    held <= level_i;
    drv <= slow_i ? held : level_i;
  end
endmodule // ispa_ctrl_model
`default_nettype wire

/* File: tb/ispa_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ispa_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [ispa_pkg::NUM_PINS-1:0] pin_i,
  input wire logic [ispa_pkg::NUM_FUNCS-1:0] func_o,
  input wire logic control_change_input_o,
  input wire logic abs_transfer_mode_input_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] st;
  logic clean;
  logic abs_p;
  logic abs_w;
  logic [1:0] mode;
  logic [2:0] cc_p;
  logic [2:0] cc_w;
  logic [14:0] hist;
  wire wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire ctl_wr = wr && avs_address_i[5:2] == 4'h0;
  wire go = st == 3'h4;
  wire [4:0] p3 = hist[14:10];
  // go: working set and mode unchanged long enough for the pin pipeline to settle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= 3'h0;
      clean <= 1'b1;
      {abs_p, abs_w, mode, cc_p, cc_w, hist} <= '0;
    end else begin
      st <= ctl_wr ? 3'h0 : (go ? st : st + 3'h1);
      clean <= clean && !ctl_wr;
      hist <= {hist[9:0], pin_i};
      if (wr && avs_address_i[5:2] == 4'h1) begin
        abs_p <= avs_writedata_i[0];
        cc_p <= avs_writedata_i[6:4];
      end
      if (ctl_wr) begin
        mode <= avs_writedata_i[1:0];
      end
      if (ctl_wr && avs_byteenable_i[1] && avs_writedata_i[8]) begin
        abs_w <= abs_p;
        cc_w <= cc_p;
      end
    end
  end
  chk_reset_routing: assert property (clean && go |-> func_o == {12'h000, p3[0], 2'b00})
    else $error("routing differs from reset settings");
  chk_mode_none: assert property (go && mode == 2'h3 |-> func_o == '0)
    else $error("function routed in empty mode");
  chk_code_zero: assert property (func_o[0] == 1'b0)
    else $error("code zero drove a function");
  chk_abs_follow: assert property (go |-> abs_transfer_mode_input_o == (abs_w && p3[3]))
    else $error("abs transfer input wrong");
  chk_cc_follow: assert property (go && !(abs_w && cc_w == 3'h4)
    |-> control_change_input_o == (cc_w != 3'h0 && cc_w <= 3'h5 && p3[cc_w - 3'h1]))
    else $error("control change input wrong");
  chk_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  chk_wait_first: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
    else $error("read answered without wait");
  chk_rd_unmapped: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[5] |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  cover property (go && abs_w && p3[3]);
  cover property (go && cc_w != 3'h0 && control_change_input_o);
  cover property (go && mode == 2'h3);
endmodule // ispa_chk
bind ispa_input_pin_assign ispa_chk u_chk (.core_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pin_i, .func_o,
  .control_change_input_o, .abs_transfer_mode_input_o);
`default_nettype wire

/* File: tb/input_signal_pin_assignment_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module input_signal_pin_assignment_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_o;
  logic [4:0] lvl = 5'h00;
  logic slow = 1'b0;
  logic [4:0] pins;
  logic [14:0] func;
  logic cc_o;
  logic abs_o;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  localparam logic [14:0] MODE_EXP [4] = '{15'h0006, 15'h0386, 15'h0006, 15'h0000};
  ispa_input_pin_assign uut (.core_clk_i, .rst_i, .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .pin_i(pins), .func_o(func), .control_change_input_o(cc_o), .abs_transfer_mode_input_o(abs_o));
  ispa_ctrl_model partner (.core_clk_i, .level_i(lvl), .slow_i(slow), .pin_o(pins));
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do begin
      @(posedge core_clk_i);
    end while (wait_o !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask
  // pin path is a few edges deep; eight covers the slow partner too
  task automatic pins_to(input logic [4:0] v);
    lvl <= v;
    repeat (8) @(posedge core_clk_i);
  endtask
  task automatic t_reset();
    rd_chk(6'h0C, 32'h0665);
    rd_chk(6'h10, 32'h0770);
    rd_chk(6'h14, 32'h0883);
    rd_chk(6'h18, 32'h0994);
    rd_chk(6'h20, 32'h0);
    pins_to(5'h1F);
    check({17'h0, func}, 32'h4);
  endtask
  task automatic t_pending();
    slow <= 1'b1;
    wr32(6'h0C, 32'h0111);
    pins_to(5'h1F);
    check({17'h0, func}, 32'h4);
    rd_chk(6'h1C, 32'h0004011F);
    wr32(6'h00, 32'h100);
    pins_to(5'h1F);
    check({17'h0, func}, 32'h6);
    slow <= 1'b0;
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr32(6'h00, 32'(m));
      pins_to(5'h1F);
      check({17'h0, func}, {17'h0, MODE_EXP[m]});
    end
    wr32(6'h00, 32'h0);
  endtask
  task automatic t_cc();
    wr32(6'h04, 32'h20);
    rd_chk(6'h04, 32'h20);
    wr32(6'h00, 32'h100);
    pins_to(5'h1F);
    check({17'h0, func}, 32'h4);
    check({31'h0, cc_o}, 32'h1);
    pins_to(5'h1D);
    check({31'h0, cc_o}, 32'h0);
  endtask
  task automatic t_abs();
    wr32(6'h14, 32'h0D00);
    wr32(6'h04, 32'h1);
    wr32(6'h00, 32'h100);
    pins_to(5'h1F);
    check({17'h0, func}, 32'h6);
    check({31'h0, abs_o}, 32'h1);
    rd_chk(6'h1C, 32'h0006021F);
    pins_to(5'h17);
    check({31'h0, abs_o}, 32'h0);
  endtask
  // a mid-run reset must bring back the reset settings and drop the absolute mode
  task automatic t_rerun();
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd_chk(6'h14, 32'h0883);
    pins_to(5'h1F);
    check({17'h0, func}, 32'h4);
    check({31'h0, abs_o}, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset();
    t_pending();
    t_modes();
    t_cc();
    t_abs();
    t_rerun();
    tally_and_finish();
  end
endmodule // input_signal_pin_assignment_tb_top
`default_nettype wire
